// ---- pkg/charge_ctrl_pkg.sv ----
package charge_ctrl_pkg;

  // ------------------------------------------------------------
  // Clock and time base
  // ------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;
  // One sub-tick lasts 62.5 ms; sixteen of them make one second.
  localparam int SUBTICK_NS = 62_500_000;
  localparam int SUBTICK_CYCLES = SUBTICK_NS / CLK_PERIOD_NS;
  localparam int SUBTICKS_PER_SEC = 16;
  // Timing-capacitor setting that yields the nominal durations.
  localparam logic [7:0] SCALE_REF = 8'h10;

  // ------------------------------------------------------------
  // Charge durations in seconds
  // ------------------------------------------------------------
  localparam int SEC_PER_MIN = 60;
  localparam int PREQUAL_MIN = 33;
  localparam int FAST_MIN = 660;
  localparam int TOPOFF_FIXED_SEC = 15;
  localparam int TOPOFF_SCALED_MIN = 132;
  localparam int PREQUAL_SEC = PREQUAL_MIN * SEC_PER_MIN;
  localparam int FAST_SEC = FAST_MIN * SEC_PER_MIN;
  localparam int TOPOFF_SCALED_SEC = TOPOFF_SCALED_MIN * SEC_PER_MIN;
  localparam int TIMER_WIDTH = 16;

  // ------------------------------------------------------------
  // Charger states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_PREQUAL,
    ST_FAST,
    ST_TOPOFF,
    ST_DONE,
    ST_FAULT
  } charge_state_t;

endpackage

// ---- rtl/charge_tick_gen.sv ----
`timescale 1ns/1ps
module charge_tick_gen #(
  parameter int SUBTICK_CYC = charge_ctrl_pkg::SUBTICK_CYCLES,
  parameter int SCALE_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [SCALE_W-1:0] scale_i,
  output logic sec_tick_o,
  output logic scaled_tick_o
);
  import charge_ctrl_pkg::*;

  localparam int SUB_W = $clog2(SUBTICK_CYC + 1);
  localparam int SEC_W = $clog2(SUBTICKS_PER_SEC);

  if (SUBTICK_CYC < 1) begin : g_bad_sub
    $error("Sub-tick must last at least one cycle.");
  end

  logic [SUB_W-1:0] sub_cnt_reg;
  logic [SEC_W-1:0] sec_cnt_reg;
  logic [SCALE_W-1:0] scl_cnt_reg;
  wire sub_wrap = (sub_cnt_reg == SUB_W'(SUBTICK_CYC - 1));
  wire sec_wrap = (sec_cnt_reg == SEC_W'(SUBTICKS_PER_SEC - 1));
  // A zero setting is served as the shortest scale rather than stalling.
  wire [SCALE_W-1:0] scale_last = (scale_i == '0) ? '0 : scale_i - SCALE_W'(1);
  wire scl_wrap = (scl_cnt_reg >= scale_last);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sub_cnt_reg <= '0;
      sec_cnt_reg <= '0;
      scl_cnt_reg <= '0;
      sec_tick_o <= 1'b0;
      scaled_tick_o <= 1'b0;
    end else begin
      sub_cnt_reg <= sub_wrap ? '0 : sub_cnt_reg + SUB_W'(1);
      sec_tick_o <= sub_wrap && sec_wrap;
      scaled_tick_o <= sub_wrap && scl_wrap;
      if (sub_wrap) begin
        sec_cnt_reg <= sec_wrap ? '0 : sec_cnt_reg + SEC_W'(1);
        scl_cnt_reg <= scl_wrap ? '0 : scl_cnt_reg + SCALE_W'(1);
      end
    end
  end
endmodule

// ---- rtl/charge_stage_timer.sv ----
`timescale 1ns/1ps
module charge_stage_timer #(
  parameter int W = charge_ctrl_pkg::TIMER_WIDTH
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic advance_i,
  input wire logic [W-1:0] limit_i,
  output logic [W-1:0] count_o,
  output logic expired_o
);
  import charge_ctrl_pkg::*;

  // The count saturates at the limit so a held expiry cannot wrap away.
  always_ff @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      count_o <= '0;
    end else if (advance_i && (count_o < limit_i)) begin
      count_o <= count_o + W'(1);
    end
  end

  assign expired_o = (count_o >= limit_i);
endmodule

// ---- rtl/charge_state_ctrl.sv ----
`timescale 1ns/1ps
module charge_state_ctrl #(
  parameter int SUBTICK_CYC = charge_ctrl_pkg::SUBTICK_CYCLES,
  parameter int PREQUAL_S = charge_ctrl_pkg::PREQUAL_SEC,
  parameter int FAST_S = charge_ctrl_pkg::FAST_SEC,
  parameter int TOPOFF_FIXED_S = charge_ctrl_pkg::TOPOFF_FIXED_SEC,
  parameter int TOPOFF_SCALED_S = charge_ctrl_pkg::TOPOFF_SCALED_SEC,
  parameter bit SCALED_TOPOFF = 1'b0,
  parameter bit BATT_DETECT = 1'b0,
  parameter int TIMER_W = charge_ctrl_pkg::TIMER_WIDTH,
  parameter int SCALE_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic charge_disable_in_i,
  input wire logic input_valid_i,
  input wire logic bat_below_prequal_i,
  input wire logic voltage_mode_i,
  input wire logic bat_below_restart_i,
  input wire logic cur_below_term_i,
  input wire logic cur_below_half_i,
  input wire logic cur_below_fifth_i,
  input wire logic input_limit_active_i,
  input wire logic thermal_limit_active_i,
  input wire logic thm_out_of_range_i,
  input wire logic thm_above_removal_i,
  input wire logic thm_below_disable_i,
  input wire logic [SCALE_W-1:0] timer_scale_i,
  output logic charge_enable_o,
  output logic prequal_current_o,
  output logic power_inputs_enable_o,
  output logic charging_indicator_n_o,
  output logic charging_indicator_oe_o,
  output logic fault_indicator_n_o,
  output logic fault_indicator_oe_o,
  output charge_ctrl_pkg::charge_state_t state_o
);
  import charge_ctrl_pkg::*;

  if ((PREQUAL_S >= 2 ** TIMER_W) || (FAST_S >= 2 ** TIMER_W) ||
      (TOPOFF_FIXED_S >= 2 ** TIMER_W) || (TOPOFF_SCALED_S >= 2 ** TIMER_W) ||
      (PREQUAL_S < 1) || (FAST_S < 1) || (SCALE_W < 1)) begin : g_bad_cfg
    $error("Timer limits do not fit the timer width.");
  end

  // ------------------------------------------------------------
  // Time base and conditioning
  // ------------------------------------------------------------
  logic sec_tick;
  logic scaled_tick;

  charge_tick_gen #(
    .SUBTICK_CYC(SUBTICK_CYC),
    .SCALE_W(SCALE_W)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .scale_i(timer_scale_i),
    .sec_tick_o(sec_tick),
    .scaled_tick_o(scaled_tick)
  );

  charge_state_t state_reg;
  charge_state_t state_next;
  logic suspend_reg;
  logic half_phase_reg;

  wire run = input_valid_i && !charge_disable_in_i;
  wire thm_active = !thm_below_disable_i;
  wire suspend_next = thm_active && thm_out_of_range_i;
  wire go = run && !suspend_reg;
  wire term_ok = cur_below_term_i && voltage_mode_i && !input_limit_active_i &&
                 !thermal_limit_active_i;
  wire battery_absent = BATT_DETECT && thm_active && thm_above_removal_i;

  // ------------------------------------------------------------
  // Stage timers
  // ------------------------------------------------------------
  logic [TIMER_W-1:0] stage_count;
  logic [TIMER_W-1:0] topoff_count;
  logic stage_expired;
  logic topoff_expired;

  // Outside voltage mode, below half current only every other scaled tick counts; below a fifth none.
  wire fast_rate_ok = voltage_mode_i ||
                      (!cur_below_fifth_i && (!cur_below_half_i || half_phase_reg));
  wire stage_adv = scaled_tick && !suspend_reg && run &&
                   ((state_reg == ST_PREQUAL) ||
                    ((state_reg == ST_FAST) && fast_rate_ok));
  wire [TIMER_W-1:0] stage_limit = (state_reg == ST_PREQUAL) ?
                                   TIMER_W'(PREQUAL_S) : TIMER_W'(FAST_S);
  wire stage_clear = (state_next != state_reg);
  wire topoff_tick = SCALED_TOPOFF ? scaled_tick : sec_tick;
  wire [TIMER_W-1:0] topoff_limit = SCALED_TOPOFF ?
                                    TIMER_W'(TOPOFF_SCALED_S) : TIMER_W'(TOPOFF_FIXED_S);
  wire topoff_adv = topoff_tick && go && (state_reg == ST_TOPOFF);
  wire topoff_clear = (state_reg != ST_TOPOFF);

  charge_stage_timer #(.W(TIMER_W)) u_stage_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(stage_clear),
    .advance_i(stage_adv),
    .limit_i(stage_limit),
    .count_o(stage_count),
    .expired_o(stage_expired)
  );

  charge_stage_timer #(.W(TIMER_W)) u_topoff_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(topoff_clear),
    .advance_i(topoff_adv),
    .limit_i(topoff_limit),
    .count_o(topoff_count),
    .expired_o(topoff_expired)
  );

  // ------------------------------------------------------------
  // Charge sequence
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!run) begin
      state_next = ST_OFF;
    end else if (!suspend_reg) begin
      unique case (state_reg)
        ST_OFF: begin
          state_next = bat_below_prequal_i ? ST_PREQUAL : ST_FAST;
        end
        ST_PREQUAL: begin
          if (stage_expired) begin
            state_next = ST_FAULT;
          end else if (!bat_below_prequal_i) begin
            state_next = ST_FAST;
          end
        end
        ST_FAST: begin
          if (stage_expired) begin
            state_next = ST_FAULT;
          end else if (term_ok) begin
            state_next = ST_TOPOFF;
          end
        end
        ST_TOPOFF: begin
          if (topoff_expired) begin
            state_next = ST_DONE;
          end
        end
        ST_DONE: begin
          if (bat_below_restart_i) begin
            state_next = ST_FAST;
          end
        end
        ST_FAULT: begin
          state_next = ST_FAULT;
        end
      endcase
    end
  end

  wire charging_next = (state_next == ST_PREQUAL) || (state_next == ST_FAST);
  wire delivering_next = charging_next || (state_next == ST_TOPOFF);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= ST_OFF;
      suspend_reg <= 1'b0;
      half_phase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      suspend_reg <= suspend_next;
      if (scaled_tick) begin
        half_phase_reg <= !half_phase_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      charge_enable_o <= 1'b0;
      prequal_current_o <= 1'b0;
      power_inputs_enable_o <= 1'b1;
      charging_indicator_n_o <= 1'b0;
      charging_indicator_oe_o <= 1'b0;
      fault_indicator_n_o <= 1'b0;
      fault_indicator_oe_o <= 1'b0;
      state_o <= ST_OFF;
    end else begin
      charge_enable_o <= delivering_next && !suspend_next;
      prequal_current_o <= (state_next == ST_PREQUAL);
      power_inputs_enable_o <= !battery_absent;
      charging_indicator_oe_o <= charging_next && !suspend_next;
      fault_indicator_oe_o <= (state_next == ST_FAULT);
      state_o <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_fast_terminating;
    (state_reg == ST_FAST) && run && !suspend_reg && !stage_expired && term_ok;
  endsequence

  sequence s_in_topoff;
    (state_reg == ST_TOPOFF) && charge_enable_o;
  endsequence

  AST_PREQUAL_ENTRY: assert property (
    (state_reg == ST_OFF) && go && bat_below_prequal_i
    |=> (state_reg == ST_PREQUAL) && prequal_current_o)
    else $error("Prequal not entered with ten percent current.");

  AST_TERM_TOPOFF: assert property (
    s_fast_terminating ##1 (run && !suspend_reg) |-> s_in_topoff)
    else $error("Termination did not start the top-off interval.");

  AST_LIMITER_NO_TERM: assert property (
    (state_reg == ST_FAST) && (input_limit_active_i || thermal_limit_active_i)
    |=> (state_reg != ST_TOPOFF))
    else $error("Termination declared while a limiter was active.");

  AST_RESTART: assert property (
    (state_reg == ST_DONE) && go && bat_below_restart_i |=> (state_reg == ST_FAST))
    else $error("Restart from done did not begin fast charge.");

  AST_CHG_LOW: assert property (
    ((state_o == ST_PREQUAL) || (state_o == ST_FAST)) && !suspend_reg
    |-> charging_indicator_oe_o && !charging_indicator_n_o)
    else $error("Charging indicator not pulled low while charging.");

  AST_CHG_SUSPEND: assert property (
    suspend_reg |-> !charging_indicator_oe_o && !charge_enable_o)
    else $error("Charging indicator driven during temperature suspend.");

  AST_FAULT_ON_TIMEOUT: assert property (
    (state_reg == ST_FAST) && go && stage_expired
    |=> (state_reg == ST_FAULT) && fault_indicator_oe_o)
    else $error("Fast-charge timeout did not raise fault.");

  AST_FAULT_HOLDS: assert property (
    (state_reg == ST_FAULT) && run |=> (state_reg == ST_FAULT))
    else $error("Fault left without disable toggle or input removal.");

  AST_TIMER_HOLD: assert property (
    suspend_reg && run && (state_reg != ST_OFF) |=> $stable(stage_count))
    else $error("Stage timer moved during temperature suspend.");

  AST_FAST_FROZEN: assert property (
    (state_reg == ST_FAST) && scaled_tick && cur_below_fifth_i && !voltage_mode_i &&
    !stage_clear |=> $stable(stage_count))
    else $error("Fast timer advanced below one fifth of current.");

  AST_THM_DISABLED: assert property (
    thm_below_disable_i |=> !suspend_reg && power_inputs_enable_o)
    else $error("Grounded thermistor still acted on charging or power.");

  AST_BATT_REMOVED: assert property (
    battery_absent |=> !power_inputs_enable_o)
    else $error("Battery removal did not disable power inputs.");
endmodule

// ---- tb/charge_host_model.sv ----
`timescale 1ns/1ps
module charge_host_model (
  input wire logic mclk_i,
  input wire logic chg_oe_i,
  input wire logic chg_data_i,
  input wire logic flt_oe_i,
  input wire logic flt_data_i,
  input wire logic clear_req_i,
  output logic chg_pin_o,
  output logic flt_pin_o,
  output logic charge_disable_o
);
  // ------------------------------------------------------------
  // Host side of the status lines
  // ------------------------------------------------------------
  // Pull-ups hold both status lines high whenever the charger lets go.
  assign chg_pin_o = chg_oe_i ? chg_data_i : 1'b1;
  assign flt_pin_o = flt_oe_i ? flt_data_i : 1'b1;
  // The host holds the disable line high while it wants charging stopped.
  always @(posedge mclk_i) begin
    charge_disable_o <= clear_req_i;
  end
endmodule

// ---- tb/charge_state_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module charge_state_ctrl_tb_top;
  import charge_ctrl_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int SC = 4;
  localparam int PQ = 3;
  localparam int FS = 5;
  localparam int TO = 2;
  localparam int TK = 16 * SC;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clear_req = 1'b0;
  logic dis, valid, below_pq, vmode, below_rs, below_term, below_half, below_fifth;
  logic in_lim, th_lim, thm_oor, thm_rem, thm_gnd;
  logic [7:0] scale;
  logic chg_en, pq_cur, pwr_en, chg_n, chg_oe, flt_n, flt_oe, chg_pin, flt_pin;
  charge_state_t st;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  always #4 mclk_i = ~mclk_i;

  charge_state_ctrl #(.SUBTICK_CYC(SC), .PREQUAL_S(PQ), .FAST_S(FS),
    .TOPOFF_FIXED_S(TO), .BATT_DETECT(1'b1)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .charge_disable_in_i(dis),
    .input_valid_i(valid), .bat_below_prequal_i(below_pq),
    .voltage_mode_i(vmode), .bat_below_restart_i(below_rs),
    .cur_below_term_i(below_term), .cur_below_half_i(below_half),
    .cur_below_fifth_i(below_fifth), .input_limit_active_i(in_lim),
    .thermal_limit_active_i(th_lim), .thm_out_of_range_i(thm_oor),
    .thm_above_removal_i(thm_rem), .thm_below_disable_i(thm_gnd),
    .timer_scale_i(scale), .charge_enable_o(chg_en),
    .prequal_current_o(pq_cur), .power_inputs_enable_o(pwr_en),
    .charging_indicator_n_o(chg_n), .charging_indicator_oe_o(chg_oe),
    .fault_indicator_n_o(flt_n), .fault_indicator_oe_o(flt_oe), .state_o(st));

  charge_host_model host (.mclk_i(mclk_i), .chg_oe_i(chg_oe), .chg_data_i(chg_n),
    .flt_oe_i(flt_oe), .flt_data_i(flt_n), .clear_req_i(clear_req),
    .chg_pin_o(chg_pin), .flt_pin_o(flt_pin), .charge_disable_o(dis));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_st(input charge_state_t s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      step(1);
      n++;
    end
  endtask

  task automatic in_rng(input string what, input int lo, input int hi);
    check(what, 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic clear_fault();
    clear_req = 1'b1;
    step(3);
    check("cleared", st, ST_OFF);
    check("flt_off", flt_pin, 1'b1);
    clear_req = 1'b0;
    step(1);
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {below_rs, vmode, below_term, below_half, below_fifth} = 5'h00;
    {in_lim, th_lim, thm_oor, thm_rem, thm_gnd} = 5'h00;
    valid = 1'b1;
    below_pq = 1'b1;
    scale = 8'h10;
    step(12);
    check("rst_st", st, ST_OFF);
    check("rst_pwr", pwr_en, 1'b1);
    rst_i = 1'b0;
    wait_st(ST_PREQUAL, 4);
    check("pq_st", st, ST_PREQUAL);
    check("pq_cur", pq_cur, 1'b1);
    check("chg_pq", chg_pin, 1'b0);
    wait_st(ST_FAULT, 400);
    in_rng("pq_t16", (PQ - 1) * TK, PQ * TK + 4);
    check("flt_on", flt_pin, 1'b0);
    check("chg_flt", chg_pin, 1'b1);
    check("en_flt", chg_en, 1'b0);
    below_pq = 1'b0;
    below_rs = 1'b1;
    step(50);
    check("flt_hold", st, ST_FAULT);
    below_rs = 1'b0;
    below_pq = 1'b1;
    scale = 8'h20;
    clear_fault();
    wait_st(ST_PREQUAL, 4);
    wait_st(ST_FAULT, 800);
    in_rng("pq_t32", (PQ - 1) * 2 * TK, PQ * 2 * TK + 4);
    valid = 1'b0;
    step(2);
    check("unplug", st, ST_OFF);
    valid = 1'b1;
    scale = 8'h10;
    wait_st(ST_PREQUAL, 4);
    below_pq = 1'b0;
    step(2);
    check("pq_fast", st, ST_FAST);
    check("pq_cur0", pq_cur, 1'b0);
    check("chg_fast", chg_pin, 1'b0);
    vmode = 1'b1;
    below_term = 1'b1;
    th_lim = 1'b1;
    step(60);
    check("th_lim", st, ST_FAST);
    th_lim = 1'b0;
    in_lim = 1'b1;
    step(20);
    check("in_lim", st, ST_FAST);
    in_lim = 1'b0;
    vmode = 1'b0;
    step(20);
    check("no_vmode", st, ST_FAST);
    vmode = 1'b1;
    step(2);
    check("topoff", st, ST_TOPOFF);
    check("chg_top", chg_pin, 1'b1);
    check("en_top", chg_en, 1'b1);
    wait_st(ST_DONE, 300);
    in_rng("top_t", (TO - 1) * TK, TO * TK + 4);
    check("en_done", chg_en, 1'b0);
    {below_term, vmode} = 2'h0;
    step(30);
    check("done_hold", st, ST_DONE);
    below_rs = 1'b1;
    step(2);
    check("restart", st, ST_FAST);
    below_rs = 1'b0;
    step(3 * TK);
    thm_oor = 1'b1;
    step(2);
    check("chg_susp", chg_pin, 1'b1);
    check("en_susp", chg_en, 1'b0);
    step(1000);
    check("st_susp", st, ST_FAST);
    check("flt_susp", flt_pin, 1'b1);
    thm_oor = 1'b0;
    step(2);
    check("chg_res", chg_pin, 1'b0);
    wait_st(ST_FAULT, 400);
    in_rng("res_t", 1, (FS - 2) * TK + 8);
    below_half = 1'b1;
    clear_fault();
    wait_st(ST_FAST, 4);
    wait_st(ST_FAULT, 800);
    in_rng("half_t", (2 * FS - 2) * TK, (2 * FS + 1) * TK + 4);
    below_fifth = 1'b1;
    clear_fault();
    wait_st(ST_FAST, 4);
    step(1000);
    check("frozen", st, ST_FAST);
    vmode = 1'b1;
    wait_st(ST_FAULT, 400);
    in_rng("vm_t", (FS - 1) * TK, FS * TK + 4);
    {below_half, below_fifth, vmode} = 3'h0;
    clear_fault();
    wait_st(ST_FAST, 4);
    thm_gnd = 1'b1;
    thm_oor = 1'b1;
    step(3);
    check("chg_gnd", chg_pin, 1'b0);
    check("en_gnd", chg_en, 1'b1);
    thm_rem = 1'b1;
    step(3);
    check("pwr_gnd", pwr_en, 1'b1);
    thm_gnd = 1'b0;
    step(3);
    check("pwr_rem", pwr_en, 1'b0);
    end_of_test();
  end
endmodule
